// ### hdl/fsgr_consts.svh
`ifndef FSGR_CONSTS_SVH
`define FSGR_CONSTS_SVH

// register indices; byte address is four times the index
`define FSGR_IDX_FAULT_CTRL 6'h04
`define FSGR_IDX_POS_STAT   6'h12
`define FSGR_IDX_NEG_STAT   6'h13
`define FSGR_IDX_GPIO       6'h14

// reset values
`define FSGR_RST_CTRL 3'h0
`define FSGR_RST_STAT 8'h00
`define FSGR_RST_GPIO 8'h0f

// field positions
`define FSGR_THR_MSB  7
`define FSGR_THR_LSB  5
`define FSGR_DATA_MSB 7
`define FSGR_DATA_LSB 4
`define FSGR_DIR_MSB  3
`define FSGR_DIR_LSB  0

// threshold levels in per mille of full scale
`define FSGR_FULL_PERMILLE 32'h3e8
`define FSGR_HI_0 32'h3b6
`define FSGR_HI_1 32'h39d
`define FSGR_HI_2 32'h384
`define FSGR_HI_3 32'h36b
`define FSGR_HI_4 32'h352
`define FSGR_HI_5 32'h320
`define FSGR_HI_6 32'h2ee
`define FSGR_HI_7 32'h2bc
`define FSGR_LO_0 32'h032
`define FSGR_LO_1 32'h04b
`define FSGR_LO_2 32'h064
`define FSGR_LO_3 32'h07d
`define FSGR_LO_4 32'h096
`define FSGR_LO_5 32'h0c8
`define FSGR_LO_6 32'h0fa
`define FSGR_LO_7 32'h12c

`endif

// ### hdl/fsgr_pkg.sv
package fsgr_pkg;

	typedef struct packed {
		logic [7:0] pos_stat;
		logic [7:0] neg_stat;
		logic [2:0] thr_sel;
		logic [3:0] pin_data;
		logic [3:0] pin_dir;
		logic [3:0] pin_sync1;
		logic [3:0] pin_sync2;
		logic       ack;
		logic [7:0] rdata;
	} fsgr_state_s;

endpackage

// ### hdl/fsgr_regs.sv
// Overview of operation
// - positive fault status at index 12h
// - negative fault status at index 13h
// - bit n reports channel n
// - status registers read-only, reset to zero
// - flags compare inputs against selected threshold
// - threshold code picks high/low level pair
// - gpio register resets to 0Fh
// - data field reads actual pin levels
// - pin already output before the write drives written data bit
// - pin that was input before the write ignores data bit writes
// - direction bit zero output, one input
// - each direction bit governs one pin
`timescale 1ns/1ps
`include "fsgr_consts.svh"

module fsgr_regs #(
	parameter int CH = 8,
	parameter int LW = 12
) (
	input  wire logic                    REF_CLK,
	input  wire logic                    NRST,
	input  wire logic [7:0]              AVS_ADDRESS,
	input  wire logic                    AVS_READ,
	input  wire logic                    AVS_WRITE,
	input  wire logic [3:0]              AVS_BYTEENABLE,
	input  wire logic [31:0]             AVS_WRITEDATA,
	output logic      [31:0]             AVS_READDATA,
	output logic                         AVS_WAITREQUEST,
	input  wire logic [CH-1:0][LW-1:0]   POS_LEVEL,
	input  wire logic [CH-1:0][LW-1:0]   NEG_LEVEL,
	input  wire logic [3:0]              GPIO_IN,
	output logic      [3:0]              GPIO_OUT,
	output logic      [3:0]              GPIO_OE
);

	//----------------------------------------------------------------
	// parameter checks
	//----------------------------------------------------------------
	if (CH < 1 || CH > 8) begin : g_bad_ch
		$error("CH must be 1 to 8");
	end
	if (LW < 2 || LW > 16) begin : g_bad_lw
		$error("LW must be 2 to 16");
	end

	localparam fsgr_pkg::fsgr_state_s RST = '{
		pos_stat:  `FSGR_RST_STAT,
		neg_stat:  `FSGR_RST_STAT,
		thr_sel:   `FSGR_RST_CTRL,
		pin_data:  4'(`FSGR_RST_GPIO >> `FSGR_DATA_LSB),
		pin_dir:   4'(`FSGR_RST_GPIO),
		pin_sync1: 4'h0,
		pin_sync2: 4'h0,
		ack:       1'b0,
		rdata:     8'h00
	};

	fsgr_pkg::fsgr_state_s s_q;
	fsgr_pkg::fsgr_state_s s_d;

	//----------------------------------------------------------------
	// functions
	//----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
		hit = (addr == {idx, 2'b00});
	endfunction

	function automatic logic [31:0] hi_pm(input logic [2:0] code);
		case (code)
			3'h0: hi_pm = `FSGR_HI_0;
			3'h1: hi_pm = `FSGR_HI_1;
			3'h2: hi_pm = `FSGR_HI_2;
			3'h3: hi_pm = `FSGR_HI_3;
			3'h4: hi_pm = `FSGR_HI_4;
			3'h5: hi_pm = `FSGR_HI_5;
			3'h6: hi_pm = `FSGR_HI_6;
			default: hi_pm = `FSGR_HI_7;
		endcase
	endfunction

	function automatic logic [31:0] lo_pm(input logic [2:0] code);
		case (code)
			3'h0: lo_pm = `FSGR_LO_0;
			3'h1: lo_pm = `FSGR_LO_1;
			3'h2: lo_pm = `FSGR_LO_2;
			3'h3: lo_pm = `FSGR_LO_3;
			3'h4: lo_pm = `FSGR_LO_4;
			3'h5: lo_pm = `FSGR_LO_5;
			3'h6: lo_pm = `FSGR_LO_6;
			default: lo_pm = `FSGR_LO_7;
		endcase
	endfunction

	// out of range: above the high-side or below the low-side level
	function automatic logic oor(input logic [LW-1:0] lvl, input logic [2:0] code);
		logic [31:0] scaled;
		logic [31:0] fs;
		scaled = 32'(lvl) * `FSGR_FULL_PERMILLE;
		fs     = 32'((33'h1 << LW) - 33'h1);
		oor    = (scaled > hi_pm(code) * fs) || (scaled < lo_pm(code) * fs);
	endfunction

	//----------------------------------------------------------------
	// next state
	//----------------------------------------------------------------
	logic req;
	logic wr_acc;
	logic [7:0] wb;

	always_comb
	begin
		s_d    = s_q;
		req    = AVS_READ | AVS_WRITE;
		wr_acc = AVS_WRITE & s_q.ack & AVS_BYTEENABLE[0];
		wb     = AVS_WRITEDATA[7:0];
		s_d.ack = req & ~s_q.ack;
		// comparator flags, registered every cycle without latching
		for (int i = 0; i < 8; i++)
		begin
			s_d.pos_stat[i] = (i < CH) ? oor(POS_LEVEL[i % CH], s_q.thr_sel) : 1'b0;
			s_d.neg_stat[i] = (i < CH) ? oor(NEG_LEVEL[i % CH], s_q.thr_sel) : 1'b0;
		end
		s_d.pin_sync1 = GPIO_IN;
		s_d.pin_sync2 = s_q.pin_sync1;
		if (req & ~s_q.ack)
		begin
			if (hit(AVS_ADDRESS, `FSGR_IDX_FAULT_CTRL))
				s_d.rdata = {s_q.thr_sel, 5'h00};
			else if (hit(AVS_ADDRESS, `FSGR_IDX_POS_STAT))
				s_d.rdata = s_q.pos_stat;
			else if (hit(AVS_ADDRESS, `FSGR_IDX_NEG_STAT))
				s_d.rdata = s_q.neg_stat;
			else if (hit(AVS_ADDRESS, `FSGR_IDX_GPIO))
				s_d.rdata = {s_q.pin_sync2, s_q.pin_dir};
			else
				s_d.rdata = 8'h00;
		end
		// status registers have no write path
		if (wr_acc && hit(AVS_ADDRESS, `FSGR_IDX_FAULT_CTRL))
			s_d.thr_sel = wb[`FSGR_THR_MSB:`FSGR_THR_LSB];
		if (wr_acc && hit(AVS_ADDRESS, `FSGR_IDX_GPIO))
		begin
			// data bits of input pins keep their value
			s_d.pin_data = (s_q.pin_data & s_q.pin_dir)
				| (wb[`FSGR_DATA_MSB:`FSGR_DATA_LSB] & ~s_q.pin_dir);
			s_d.pin_dir = wb[`FSGR_DIR_MSB:`FSGR_DIR_LSB];
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!NRST)
			s_q <= RST;
		else
			s_q <= s_d;
	end

	//----------------------------------------------------------------
	// outputs
	//----------------------------------------------------------------
	assign AVS_WAITREQUEST = req & ~s_q.ack;
	assign AVS_READDATA    = {24'h000000, s_q.rdata};
	assign GPIO_OUT        = s_q.pin_data;
	assign GPIO_OE         = ~s_q.pin_dir;

	//----------------------------------------------------------------
	// assertions
	//----------------------------------------------------------------
	localparam logic [7:0] A_POS  = {`FSGR_IDX_POS_STAT, 2'b00};
	localparam logic [7:0] A_NEG  = {`FSGR_IDX_NEG_STAT, 2'b00};
	localparam logic [7:0] A_GPIO = {`FSGR_IDX_GPIO, 2'b00};
	localparam logic [7:0] A_CTRL = {`FSGR_IDX_FAULT_CTRL, 2'b00};

	sequence s_rd_done(logic [7:0] a);
		AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == a;
	endsequence

	sequence s_gpio_wr;
		AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == A_GPIO && AVS_BYTEENABLE[0];
	endsequence

	sequence s_ctrl_wr;
		AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == A_CTRL && AVS_BYTEENABLE[0];
	endsequence

	sequence s_stat_wr;
		AVS_WRITE && !AVS_WAITREQUEST && (AVS_ADDRESS == A_POS || AVS_ADDRESS == A_NEG);
	endsequence

	// one wait cycle, then the answer
	sequence s_one_wait;
		AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
	endsequence

	property p_pos_track;
		@(posedge REF_CLK) disable iff (!NRST)
		$past(NRST) |-> s_q.pos_stat[0] == $past(oor(POS_LEVEL[0], s_q.thr_sel));
	endproperty
	a_pos_track: assert property (p_pos_track) else $error("pos flag stale");

	property p_neg_track;
		@(posedge REF_CLK) disable iff (!NRST)
		$past(NRST) |-> s_q.neg_stat[CH-1] == $past(oor(NEG_LEVEL[CH-1], s_q.thr_sel));
	endproperty
	a_neg_track: assert property (p_neg_track) else $error("neg flag stale");

	property p_rd_pos;
		@(posedge REF_CLK) disable iff (!NRST)
		s_rd_done(A_POS) |-> AVS_READDATA == {24'h000000, $past(s_q.pos_stat)};
	endproperty
	a_rd_pos: assert property (p_rd_pos) else $error("pos read wrong");

	property p_stat_reset;
		@(posedge REF_CLK)
		$past(!NRST) |-> s_q.pos_stat == `FSGR_RST_STAT && s_q.neg_stat == `FSGR_RST_STAT;
	endproperty
	a_stat_reset: assert property (p_stat_reset) else $error("status not reset");

	property p_tight;
		@(posedge REF_CLK) disable iff (!NRST)
		(s_q.thr_sel == 3'h0 && POS_LEVEL[0] == '0) |=> s_q.pos_stat[0];
	endproperty
	a_tight: assert property (p_tight) else $error("low side missed");

	property p_gpio_reset;
		@(posedge REF_CLK)
		$past(!NRST) |-> GPIO_OE == 4'h0 && GPIO_OUT == 4'h0;
	endproperty
	a_gpio_reset: assert property (p_gpio_reset) else $error("gpio reset wrong");

	property p_rd_pin;
		@(posedge REF_CLK) disable iff (!NRST)
		s_rd_done(A_GPIO) |-> AVS_READDATA[7:4] == $past(s_q.pin_sync2);
	endproperty
	a_rd_pin: assert property (p_rd_pin) else $error("pin read wrong");

	property p_wr_data;
		@(posedge REF_CLK) disable iff (!NRST)
		s_gpio_wr |=> GPIO_OUT == (($past(GPIO_OUT) & ~$past(GPIO_OE))
			| ($past(AVS_WRITEDATA[7:4]) & $past(GPIO_OE)));
	endproperty
	a_wr_data: assert property (p_wr_data) else $error("data write wrong");

	property p_wr_dir;
		@(posedge REF_CLK) disable iff (!NRST)
		s_gpio_wr |=> GPIO_OE == ~$past(AVS_WRITEDATA[3:0]);
	endproperty
	a_wr_dir: assert property (p_wr_dir) else $error("direction write wrong");

	property p_sync;
		@(posedge REF_CLK) disable iff (!NRST)
		NRST ##1 NRST |=> s_q.pin_sync2 == $past(GPIO_IN, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("pin sync wrong");

	property p_rd_neg;
		@(posedge REF_CLK) disable iff (!NRST)
		s_rd_done(A_NEG) |-> AVS_READDATA == {24'h000000, $past(s_q.neg_stat)};
	endproperty
	a_rd_neg: assert property (p_rd_neg) else $error("neg read wrong");

	property p_rd_dir;
		@(posedge REF_CLK) disable iff (!NRST)
		s_rd_done(A_GPIO) |-> AVS_READDATA[3:0] == ~$past(GPIO_OE);
	endproperty
	a_rd_dir: assert property (p_rd_dir) else $error("direction read wrong");

	property p_stat_ro;
		@(posedge REF_CLK) disable iff (!NRST)
		s_stat_wr |=> $stable(s_q.thr_sel) && $stable(s_q.pin_data) && $stable(s_q.pin_dir);
	endproperty
	a_stat_ro: assert property (p_stat_ro) else $error("status write leaked");

	property p_in_hold;
		@(posedge REF_CLK) disable iff (!NRST)
		s_gpio_wr |=> ((GPIO_OUT ^ $past(GPIO_OUT)) & ~$past(GPIO_OE)) == 4'h0;
	endproperty
	a_in_hold: assert property (p_in_hold) else $error("input pin data changed");

	property p_oe_hold;
		@(posedge REF_CLK) disable iff (!NRST)
		$changed(GPIO_OE) |-> $past(AVS_WRITE && !AVS_WAITREQUEST
			&& AVS_ADDRESS == A_GPIO && AVS_BYTEENABLE[0]);
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("direction changed alone");

	property p_thr_wr;
		@(posedge REF_CLK) disable iff (!NRST)
		s_ctrl_wr |=> s_q.thr_sel == $past(AVS_WRITEDATA[`FSGR_THR_MSB:`FSGR_THR_LSB]);
	endproperty
	a_thr_wr: assert property (p_thr_wr) else $error("threshold write wrong");

	property p_neg_low;
		@(posedge REF_CLK) disable iff (!NRST)
		(s_q.thr_sel == 3'h7 && NEG_LEVEL[0] == '0) |=> s_q.neg_stat[0];
	endproperty
	a_neg_low: assert property (p_neg_low) else $error("neg low side missed");

	property p_one_wait;
		@(posedge REF_CLK) disable iff (!NRST)
		$rose(AVS_READ || AVS_WRITE) |-> s_one_wait;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait cycle wrong");

endmodule // fsgr_regs

// ### tb/fsgr_pin_model.sv
`timescale 1ns/1ps
module fsgr_pin_model (
	input  wire logic [3:0] oe,
	input  wire logic [3:0] drv,
	input  wire logic [3:0] ext,
	output logic      [3:0] pin
);
	// a pin follows the device while it drives, else the outside level
	assign pin = (oe & drv) | (~oe & ext);
endmodule // fsgr_pin_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic             clk;
	logic             nrst;
	logic [7:0]       addr;
	logic             rd_en;
	logic             wr_en;
	logic [31:0]      wdata;
	logic [31:0]      rdata;
	logic             wait_rq;
	logic [7:0][11:0] pos;
	logic [7:0][11:0] neg;
	logic [3:0]       ext;
	logic [3:0]       be;
	logic [3:0]       pin;
	logic [3:0]       gout;
	logic [3:0]       goe;
	int               fails = 0;
	int               samples_checked = 0;

	fsgr_regs DUT (.REF_CLK(clk), .NRST(nrst), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
		.AVS_WRITE(wr_en), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_rq), .POS_LEVEL(pos),
		.NEG_LEVEL(neg), .GPIO_IN(pin), .GPIO_OUT(gout), .GPIO_OE(goe));
	fsgr_pin_model PM (.oe(goe), .drv(gout), .ext(ext), .pin(pin));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		wdata <= {24'h0, d};
		rd_en <= ~w;
		wr_en <= w;
		// only the watchdog ends a wait that never finishes
		do
			@(posedge clk);
		while (wait_rq !== 1'b0);
		if (!w)
			chk(rdata, {24'h0, e});
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 8'h00);
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, e);
	endtask

	task settle;
		repeat (3) @(posedge clk);
	endtask

	task wrap_up;
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		rd(8'h48, 8'h00);
		rd(8'h4c, 8'h00);
		rd(8'h50, 8'h0f);
		chk({28'h0, goe}, 32'h0);
		rd(8'h3c, 8'h00);
	endtask

	task t_fault;
		@(posedge clk);
		pos <= {12'hfff, {5{12'h800}}, 12'hc80, 12'h000};
		neg <= {{4{12'h800}}, 12'hfff, {2{12'h800}}, 12'h000};
		settle();
		rd(8'h48, 8'h81);
		rd(8'h4c, 8'h09);
		wr(8'h48, 8'hff);
		rd(8'h48, 8'h81);
		wr(8'h10, 8'he0);
		rd(8'h48, 8'h83);
		wr(8'h10, 8'hc0);
		rd(8'h10, 8'hc0);
		rd(8'h48, 8'h83);
		@(posedge clk);
		pos <= {8{12'h800}};
		settle();
		rd(8'h48, 8'h00);
	endtask

	task t_gpio;
		wr(8'h50, 8'ha5);
		settle();
		rd(8'h50, 8'h05);
		wr(8'h50, 8'ha5);
		settle();
		rd(8'h50, 8'ha5);
		chk({28'h0, goe}, 32'ha);
		chk({28'h0, gout & 4'ha}, 32'ha);
		@(posedge clk);
		ext <= 4'hf;
		settle();
		rd(8'h50, 8'hf5);
		wr(8'h50, 8'h05);
		settle();
		rd(8'h50, 8'h55);
		// a write with byte lane 0 disabled must be ignored
		@(posedge clk);
		be <= 4'he;
		wr(8'h50, 8'hf0);
		be <= 4'hf;
		settle();
		rd(8'h50, 8'h55);
	endtask

	initial
	begin
		nrst = 1'b0;
		addr = 8'h00;
		rd_en = 1'b0;
		wr_en = 1'b0;
		wdata = 32'h0;
		pos = {8{12'h800}};
		neg = {8{12'h800}};
		ext = 4'h0;
		be = 4'hf;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_fault();
		t_gpio();
		wrap_up();
	end

	initial
	begin
		#50000;
		fails++;
		wrap_up();
	end
endmodule // tb_top
